// [verilog/irq_vector_map.svh]
`ifndef IRQ_VECTOR_MAP_SVH
`define IRQ_VECTOR_MAP_SVH

// Register indices on the plain register port
`define ADDR_PENDING     4'h0
`define ADDR_MASK        4'h1
`define ADDR_SWTRAP      4'h2
`define ADDR_VECTOR      4'h3
`define ADDR_VBASE       4'h4
`define ADDR_EVT_STATUS  4'h5
`define ADDR_EVT_CLEAR   4'h6
`define ADDR_EVT_ENABLE  4'h7

// Register layout
`define REG_WIDTH        16
`define NUM_MASKABLE     15
`define RESERVED_BIT     15
`define SHARED_BIT       8

// Reset values
`define PENDING_RST      16'h0000
`define MASK_RST         16'h0000
`define VBASE_RST        16'h0000

// Vector offsets
`define VEC_RESET        7'h00
`define VEC_NMI          7'h04
`define VEC_SW17         7'h08
`define VEC_MASKABLE0    7'h40
`define VEC_STEP         7'h04

// Hardware priority numbers
`define PRIO_RESET       5'h01
`define PRIO_NMI         5'h02
`define PRIO_MASKABLE0   5'h03
`define PRIO_NONE        5'h00

// Software trap numbers
`define TRAP_NMI_NUM     5'h10
`define TRAP_LAST_NUM    5'h1e

// Event status bits
`define EVT_TAKEN        0
`define EVT_NMI          1
`define EVT_WIDTH        2

`endif

// [verilog/irq_vector_pkg.sv]
package irq_vector_pkg;
    typedef struct packed {
        logic       valid;
        logic [6:0] offset;
        logic [4:0] priority_num;
    } vector_s;

    typedef struct packed {
        logic       ack;
    } core_ack_s;
endpackage

// [verilog/irq_vector_ctrl.sv]
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`include "irq_vector_map.svh"

// Operation
// - Both resets vector to 0x00, priority one
// - Slots four words apart; NMI 0x04, priority two
// - Software traps 17-30 at 0x08-0x3C, unprioritised
// - External requests 0-2 at 0x40-0x48, priorities 3-5
// - Timer0 0x4C; serial0 rx/tx 0x50/0x54
// - Serial2 rx/tx default 0x58/0x5C, reassignable
// - External 3 ORed with timer1 at 0x60
// - Host port 0x64; serial1 rx/tx 0x68/0x6C
// - DMA4/5 0x70/0x74; UART 0x78; 0x7C reserved
// - Pending and mask share layout, bits 0-7
// - Bits 9-14 host, serial1, DMA, UART; 15 reserved
// - Bit 8 is external 3 OR timer1
module irq_vector_ctrl
    import irq_vector_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic        RESET_REQUEST,
    input  wire logic        NMI_REQUEST,
    input  wire logic        EXT_REQUEST_0,
    input  wire logic        EXT_REQUEST_1,
    input  wire logic        EXT_REQUEST_2,
    input  wire logic        EXT_REQUEST_3,
    input  wire logic        TIMER0_REQUEST,
    input  wire logic        TIMER1_REQUEST,
    input  wire logic        SERIAL0_RX_REQUEST,
    input  wire logic        SERIAL0_TX_REQUEST,
    input  wire logic        SERIAL2_RX_REQUEST,
    input  wire logic        SERIAL2_TX_REQUEST,
    input  wire logic        ALT_SLOT6_REQUEST,
    input  wire logic        ALT_SLOT7_REQUEST,
    input  wire logic        HOST_PORT_REQUEST,
    input  wire logic        SERIAL1_RX_REQUEST,
    input  wire logic        SERIAL1_TX_REQUEST,
    input  wire logic        DMA_CH4_REQUEST,
    input  wire logic        DMA_CH5_REQUEST,
    input  wire logic        UART_REQUEST,
    input  wire logic        SLOT_SELECT,
    input  wire core_ack_s   CORE_ACK,
    output vector_s          VECTOR,
    output logic [15:0]      VECTOR_ADDR,
    input  wire logic [3:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic [15:0]      RDATA,
    output logic             IRQ
);

    ////////////////////////////////////////////////////////////////////////////
    // Request gathering

    logic [15:0]    src_req;
    logic [15:0]    src_prev_reg;
    logic [15:0]    src_rise;
    logic [15:0]    pending_reg;
    logic [15:0]    mask_reg;
    logic [15:0]    vbase_reg;
    logic [15:0]    vector_reg;
    logic           nmi_prev_reg;
    logic           nmi_pend_reg;
    logic           reset_pend_reg;
    logic           trap_pend_reg;
    logic [4:0]     trap_num_reg;
    logic [1:0]     evt_status_reg;
    logic [1:0]     evt_enable_reg;
    vector_s        vector_reg_s;
    vector_s        sel_next;
    logic [15:0]    active;
    logic [3:0]     win_idx;
    logic           win_any;
    logic           take;
    logic [15:0]    take_clear;
    logic           sw_trap_write;
    logic           slot6_src;
    logic           slot7_src;
    logic [15:0]    pend_wclr;
    logic [1:0]     evt_clr;
    logic [1:0]     evt_set;

    // Slot 6/7 may be steered to alternate sources
    assign slot6_src = SLOT_SELECT ? ALT_SLOT6_REQUEST : SERIAL2_RX_REQUEST;
    assign slot7_src = SLOT_SELECT ? ALT_SLOT7_REQUEST : SERIAL2_TX_REQUEST;

    always_comb begin
        src_req     = 16'h0000;
        src_req[0]  = EXT_REQUEST_0;
        src_req[1]  = EXT_REQUEST_1;
        src_req[2]  = EXT_REQUEST_2;
        src_req[3]  = TIMER0_REQUEST;
        src_req[4]  = SERIAL0_RX_REQUEST;
        src_req[5]  = SERIAL0_TX_REQUEST;
        src_req[6]  = slot6_src;
        src_req[7]  = slot7_src;
        // No way to tell the two apart here; software masks one at source
        src_req[`SHARED_BIT] = EXT_REQUEST_3 | TIMER1_REQUEST;
        src_req[9]  = HOST_PORT_REQUEST;
        src_req[10] = SERIAL1_RX_REQUEST;
        src_req[11] = SERIAL1_TX_REQUEST;
        src_req[12] = DMA_CH4_REQUEST;
        src_req[13] = DMA_CH5_REQUEST;
        src_req[14] = UART_REQUEST;
    end

    // Flags latch on the rising edge of a request so a held level fires once
    assign src_rise = src_req & ~src_prev_reg;

    always_ff @(posedge CLK) begin
        if (RST) begin
            src_prev_reg <= 16'h0000;
            nmi_prev_reg <= 1'b0;
        end else begin
            src_prev_reg <= src_req;
            nmi_prev_reg <= NMI_REQUEST;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prioritisation

    assign active = pending_reg & mask_reg;

    // Lowest bit index carries the lowest priority number
    always_comb begin
        win_idx = 4'h0;
        win_any = 1'b0;
        for (int i = `NUM_MASKABLE - 1; i >= 0; i--) begin
            if (active[i]) begin
                win_idx = 4'(i);
                win_any = 1'b1;
            end
        end
    end

    always_comb begin
        sel_next = '0;
        if (reset_pend_reg) begin
            sel_next = '{1'b1, `VEC_RESET, `PRIO_RESET};
        end else if (nmi_pend_reg) begin
            sel_next = '{1'b1, `VEC_NMI, `PRIO_NMI};
        end else if (trap_pend_reg) begin
            // Trap 16 shares the nonmaskable slot; 17..30 follow four words apart
            sel_next.valid        = 1'b1;
            sel_next.offset       = 7'((({2'b00, trap_num_reg} - {2'b00, `TRAP_NMI_NUM}) << 2)
                                       + `VEC_NMI);
            sel_next.priority_num = (trap_num_reg == `TRAP_NMI_NUM) ? `PRIO_NMI
                                                                  : `PRIO_NONE;
        end else if (win_any) begin
            sel_next.valid        = 1'b1;
            sel_next.offset       = `VEC_MASKABLE0 + 7'({win_idx, 2'b00});
            // UART slot has no hardware priority
            sel_next.priority_num = (win_idx == 4'd14) ? `PRIO_NONE
                                  : `PRIO_MASKABLE0 + 5'(win_idx);
        end
    end

    assign take = CORE_ACK.ack & vector_reg_s.valid;

    always_ff @(posedge CLK) begin
        if (RST) begin
            vector_reg_s <= '0;
        end else begin
            vector_reg_s <= sel_next;
        end
    end

    assign VECTOR      = vector_reg_s;
    assign VECTOR_ADDR = vector_reg;

    always_ff @(posedge CLK) begin
        if (RST) begin
            vector_reg <= `VBASE_RST;
        end else begin
            vector_reg <= vbase_reg + {9'h000, sel_next.offset};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending and special requests

    always_comb begin
        take_clear = 16'h0000;
        // Clear what was presented; a later special request must not hide the take
        if (take && vector_reg_s.offset >= `VEC_MASKABLE0) begin
            take_clear[4'(7'(vector_reg_s.offset - `VEC_MASKABLE0) >> 2)] = 1'b1;
        end
    end

    assign sw_trap_write = WR && (ADDR == `ADDR_SWTRAP);
    assign pend_wclr     = (WR && ADDR == `ADDR_PENDING) ? WDATA : 16'h0000;

    // Set wins over clear; bit 15 stays zero
    always_ff @(posedge CLK) begin
        if (RST) begin
            pending_reg <= `PENDING_RST;
        end else begin
            pending_reg <= ((pending_reg & ~pend_wclr & ~take_clear) | src_rise)
                           & ~(16'h0001 << `RESERVED_BIT);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            mask_reg <= `MASK_RST;
        end else if (WR && ADDR == `ADDR_MASK) begin
            mask_reg <= WDATA & ~(16'h0001 << `RESERVED_BIT);
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            vbase_reg <= `VBASE_RST;
        end else if (WR && ADDR == `ADDR_VBASE) begin
            vbase_reg <= {WDATA[15:7], 7'h00};
        end
    end

    // Hardware reset is a pin; software reset is trap number zero
    always_ff @(posedge CLK) begin
        if (RST) begin
            reset_pend_reg <= 1'b0;
        end else if (RESET_REQUEST || (sw_trap_write && WDATA[4:0] == 5'h00)) begin
            reset_pend_reg <= 1'b1;
        end else if (take && vector_reg_s.offset == `VEC_RESET) begin
            reset_pend_reg <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            nmi_pend_reg <= 1'b0;
        end else if (NMI_REQUEST && !nmi_prev_reg) begin
            nmi_pend_reg <= 1'b1;
        end else if (take && !reset_pend_reg && vector_reg_s.offset == `VEC_NMI) begin
            nmi_pend_reg <= 1'b0;
        end
    end

    // One software trap held at a time; a new write replaces an untaken one
    always_ff @(posedge CLK) begin
        if (RST) begin
            trap_pend_reg <= 1'b0;
            trap_num_reg  <= 5'h00;
        end else if (sw_trap_write && WDATA[4:0] >= `TRAP_NMI_NUM
                     && WDATA[4:0] <= `TRAP_LAST_NUM) begin
            trap_pend_reg <= 1'b1;
            trap_num_reg  <= WDATA[4:0];
        end else if (take && vector_reg_s.offset < `VEC_MASKABLE0
                     && (vector_reg_s.offset > `VEC_NMI
                         || (vector_reg_s.offset == `VEC_NMI && !nmi_pend_reg))) begin
            trap_pend_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Event interrupt

    assign evt_clr = (WR && ADDR == `ADDR_EVT_CLEAR) ? WDATA[1:0] : 2'b00;
    assign evt_set = {NMI_REQUEST && !nmi_prev_reg, take};

    always_ff @(posedge CLK) begin
        if (RST) begin
            evt_status_reg <= 2'b00;
        end else begin
            evt_status_reg <= (evt_status_reg & ~evt_clr) | evt_set;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            evt_enable_reg <= 2'b00;
        end else if (WR && ADDR == `ADDR_EVT_ENABLE) begin
            evt_enable_reg <= WDATA[1:0];
        end
    end

    assign IRQ = |(evt_status_reg & evt_enable_reg);

    ////////////////////////////////////////////////////////////////////////////
    // Read port

    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 16'h0000;
        end else if (RD) begin
            unique case (ADDR)
                `ADDR_PENDING:    RDATA <= pending_reg;
                `ADDR_MASK:       RDATA <= mask_reg;
                `ADDR_SWTRAP:     RDATA <= {11'h000, trap_num_reg};
                `ADDR_VECTOR:     RDATA <= vector_reg;
                `ADDR_VBASE:      RDATA <= vbase_reg;
                `ADDR_EVT_STATUS: RDATA <= {14'h0000, evt_status_reg};
                `ADDR_EVT_ENABLE: RDATA <= {14'h0000, evt_enable_reg};
                default:          RDATA <= 16'h0000;
            endcase
        end else begin
            RDATA <= 16'h0000;
        end
    end

endmodule

// [verif/irq_vector_props.sv]
`timescale 1ns/1ps
module irq_vector_props
    import irq_vector_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [3:0]  ADDR,
    input  wire logic        RD,
    input  wire logic [15:0] RDATA,
    input  wire vector_s     VECTOR,
    input  wire logic [15:0] VECTOR_ADDR
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    ////////////////////////////////////////////////////////////////////////////////
    a_reset_prio: assert property (
        VECTOR.valid && VECTOR.offset == 7'h00 |-> VECTOR.priority_num == 5'h01)
        else $error("reset slot priority wrong");
    a_nmi_prio: assert property (
        VECTOR.valid && VECTOR.offset == 7'h04 |-> VECTOR.priority_num == 5'h02)
        else $error("nonmaskable slot priority wrong");
    a_slot_align: assert property (
        VECTOR.valid |-> VECTOR.offset[1:0] == 2'b00 && VECTOR_ADDR[6:0] == VECTOR.offset)
        else $error("vector slot misaligned");
    a_trap_prio: assert property (
        VECTOR.valid && VECTOR.offset inside {[7'h08:7'h3c]} |-> VECTOR.priority_num == 5'h00)
        else $error("software trap has a priority");
    a_source_prio: assert property (
        VECTOR.valid && VECTOR.offset inside {[7'h40:7'h74]}
        |-> VECTOR.priority_num == VECTOR.offset[6:2] - 5'h0d)
        else $error("source slot priority wrong");
    a_uart_prio: assert property (
        VECTOR.valid && VECTOR.offset == 7'h78 |-> VECTOR.priority_num == 5'h00)
        else $error("uart slot priority wrong");
    a_no_reserved: assert property (
        VECTOR.valid |-> VECTOR.offset < 7'h7c)
        else $error("reserved slot presented");
    a_flag_reserved: assert property (
        $past(RD) && $past(ADDR) <= 4'h1 |-> RDATA[15] == 1'b0)
        else $error("reserved flag bit reads one");
endmodule

// [verif/core_fetch_model.sv]
`timescale 1ns/1ps
module core_fetch_model
    import irq_vector_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       RST,
    input  wire logic       EN,
    input  wire logic [3:0] DELAY,
    input  wire vector_s    VECTOR,
    output core_ack_s       CORE_ACK
);
    logic [3:0] wait_reg;
    logic [1:0] hold_reg;
    // A taken vector needs two edges to retire, so look again only after three
    always_ff @(posedge CLK) begin
        if (RST || !EN) begin
            CORE_ACK <= '0;
            wait_reg <= 4'h0;
            hold_reg <= 2'h0;
        end else if (hold_reg != 2'h0) begin
            CORE_ACK <= '0;
            hold_reg <= hold_reg - 2'h1;
        end else if (VECTOR.valid && wait_reg == DELAY) begin
            CORE_ACK <= '1;
            wait_reg <= 4'h0;
            hold_reg <= 2'h3;
        end else if (VECTOR.valid) begin
            wait_reg <= wait_reg + 4'h1;
        end
    end
endmodule

// [verif/irq_vector_ctrl_test.sv]
`timescale 1ns/1ps
module irq_vector_ctrl_test
    import irq_vector_pkg::*;
;
    typedef struct packed {
        logic       trap;
        logic [4:0] src;
        logic [6:0] off;
        logic [4:0] pri;
    } row_s;
    localparam row_s ROWS [23] = '{
        '{1'b0,5'h00,7'h40,5'h03}, '{1'b0,5'h01,7'h44,5'h04}, '{1'b0,5'h02,7'h48,5'h05},
        '{1'b0,5'h03,7'h4c,5'h06}, '{1'b0,5'h04,7'h50,5'h07}, '{1'b0,5'h05,7'h54,5'h08},
        '{1'b0,5'h06,7'h58,5'h09}, '{1'b0,5'h07,7'h5c,5'h0a}, '{1'b0,5'h08,7'h60,5'h0b},
        '{1'b0,5'h09,7'h64,5'h0c}, '{1'b0,5'h0a,7'h68,5'h0d}, '{1'b0,5'h0b,7'h6c,5'h0e},
        '{1'b0,5'h0c,7'h70,5'h0f}, '{1'b0,5'h0d,7'h74,5'h10}, '{1'b0,5'h0e,7'h78,5'h00},
        '{1'b0,5'h0f,7'h60,5'h0b}, '{1'b0,5'h10,7'h04,5'h02}, '{1'b0,5'h11,7'h58,5'h09},
        '{1'b0,5'h12,7'h5c,5'h0a}, '{1'b1,5'h00,7'h00,5'h01}, '{1'b1,5'h10,7'h04,5'h02},
        '{1'b1,5'h11,7'h08,5'h00}, '{1'b1,5'h1e,7'h3c,5'h00}};
    logic        clk;
    logic        rst;
    logic        rreq;
    logic        sel;
    logic        en;
    logic        wr;
    logic        rd;
    logic        irq;
    logic [18:0] req;
    logic [3:0]  addr;
    logic [3:0]  dly;
    logic [15:0] wdata;
    logic [15:0] base;
    logic [15:0] rdata;
    logic [15:0] vaddr;
    core_ack_s   ack;
    vector_s     vec;
    int          errors;
    int          checks;
    always #5 clk = ~clk;
    irq_vector_ctrl DUT (.CLK(clk), .RST(rst), .RESET_REQUEST(rreq), .NMI_REQUEST(req[16]),
        .EXT_REQUEST_0(req[0]), .EXT_REQUEST_1(req[1]), .EXT_REQUEST_2(req[2]),
        .EXT_REQUEST_3(req[8]), .TIMER0_REQUEST(req[3]), .TIMER1_REQUEST(req[15]),
        .SERIAL0_RX_REQUEST(req[4]), .SERIAL0_TX_REQUEST(req[5]),
        .SERIAL2_RX_REQUEST(req[6]), .SERIAL2_TX_REQUEST(req[7]),
        .ALT_SLOT6_REQUEST(req[17]), .ALT_SLOT7_REQUEST(req[18]),
        .HOST_PORT_REQUEST(req[9]), .SERIAL1_RX_REQUEST(req[10]),
        .SERIAL1_TX_REQUEST(req[11]), .DMA_CH4_REQUEST(req[12]), .DMA_CH5_REQUEST(req[13]),
        .UART_REQUEST(req[14]), .SLOT_SELECT(sel), .CORE_ACK(ack), .VECTOR(vec),
        .VECTOR_ADDR(vaddr), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .IRQ(irq));
    core_fetch_model core (.CLK(clk), .RST(rst), .EN(en), .DELAY(dly), .VECTOR(vec),
        .CORE_ACK(ack));
    ////////////////////////////////////////////////////////////////////////////////
    task chk(input logic [15:0] s, input logic [15:0] e);
        checks++;
        if (s !== e) begin
            errors++;
            $display("wrong value at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // Waits for the core to take a vector, then lets the flag retire
    task take(input logic [6:0] o, input logic [4:0] p);
        for (int n = 0; n < 40 && ack.ack !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
        chk({8'h00, vec.valid, vec.offset}, {8'h00, 1'b1, o});
        chk({11'h000, vec.priority_num}, {11'h000, p});
        chk(vaddr, base + {9'h000, o});
        repeat (4) @(posedge clk);
    endtask
    task results;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 0; rst = 1; rreq = 0; req = '0; sel = 0; en = 1; dly = 4'h0;
        wr = 0; rd = 0; addr = 4'h0; wdata = 16'h0000; base = 16'h0200;
        errors = 0; checks = 0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(4'h1, 16'h0000);
        wr_reg(4'h1, 16'hffff);
        rd_chk(4'h1, 16'h7fff);
        rd_chk(4'hf, 16'h0000);
        wr_reg(4'h4, base);
        foreach (ROWS[i]) begin
            @(posedge clk);
            sel <= ROWS[i].src > 5'h10;
            dly <= 4'(i % 3);
            if (ROWS[i].trap) wr_reg(4'h2, {11'h000, ROWS[i].src});
            else begin
                @(posedge clk);
                req <= 19'h0_0001 << ROWS[i].src;
                @(posedge clk);
                req <= '0;
            end
            take(ROWS[i].off, ROWS[i].pri);
        end
        // Three sources at once while the core looks away
        en <= 1'b0;
        @(posedge clk);
        req <= 19'h0_4005;
        @(posedge clk);
        req <= '0;
        repeat (3) @(posedge clk);
        en <= 1'b1;
        take(7'h40, 5'h03);
        take(7'h48, 5'h05);
        take(7'h78, 5'h00);
        rd_chk(4'h0, 16'h0000);
        wr_reg(4'h7, 16'h0001);
        chk({15'h0000, irq}, 16'h0001);
        rd_chk(4'h5, 16'h0003);
        wr_reg(4'h6, 16'h0003);
        chk({15'h0000, irq}, 16'h0000);
        // Shared slot: only one of the pair may be live to tell them apart
        wr_reg(4'h1, 16'h0000);
        @(posedge clk);
        req <= 19'h0_8000;
        @(posedge clk);
        req <= '0;
        rd_chk(4'h0, 16'h0100);
        wr_reg(4'h0, 16'h0100);
        rd_chk(4'h0, 16'h0000);
        en <= 1'b0;
        rreq <= 1'b1;
        repeat (4) @(posedge clk);
        rreq <= 1'b0;
        en <= 1'b1;
        take(7'h00, 5'h01);
        wr_reg(4'h1, 16'h00ff);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd_chk(4'h1, 16'h0000);
        results;
    end
    initial begin
        repeat (3000) @(posedge clk);
        errors++;
        results;
    end
endmodule
bind irq_vector_ctrl irq_vector_props props (.CLK(CLK), .RST(RST), .ADDR(ADDR), .RD(RD),
    .RDATA(RDATA), .VECTOR(VECTOR), .VECTOR_ADDR(VECTOR_ADDR));
